// ===== ssbe_cfg.svh
/*
 * Register offsets, field positions, reset values and counts of the serial channel block.
 * Assumes it is included by its bare name wherever one of these numbers is needed.
 */
`ifndef SSBE_CFG_SVH
`define SSBE_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SSBE_OFF_CTRL 12'h000
`define SSBE_OFF_BAUD 12'h004
`define SSBE_OFF_TXB 12'h008
`define SSBE_OFF_RXB 12'h00C

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define SSBE_CTRL_LSB 0
`define SSBE_FLAG_LSB 8
`define SSBE_RST_CTRL 7'h00
`define SSBE_RST_BAUD 16'h0000
`define SSBE_RST_DATA 16'h0000
`define SSBE_LINE_IDLE 1'h1

// ----------------------------------------------------------------------------
// Frame length and slave clock window shifts
// ----------------------------------------------------------------------------
`define SSBE_FRAME_BITS 5'h10
`define SSBE_RATE_LO_SH 0
`define SSBE_RATE_HI_SH 2

`endif

// ===== ssbe_pkg.sv
/*
 * Types shared by the serial channel block: control fields, error flags, channel state.
 * Assumes nothing of its surroundings.
 */
package ssbe_pkg;

    // Control fields, bit 0 is the channel enable.
    typedef struct packed {
        logic auto_reset_enable;
        logic transmit_stale_enable;
        logic rate_error_enable;
        logic phase_error_enable;
        logic receive_overrun_enable;
        logic master;
        logic channel_enable_bit;
    } ssbe_ctrl_s;

    // Sticky error flags, bit 0 is the receive overrun.
    typedef struct packed {
        logic transmit_stale_flag;
        logic rate_error_flag;
        logic phase_error_flag;
        logic receive_overrun_flag;
    } ssbe_err_s;

    // Channel transfer state.
    typedef enum logic {
        SSBE_CH_IDLE,
        SSBE_CH_BUSY
    } ssbe_chan_e;

endpackage : ssbe_pkg

// ===== ssbe_channel.sv
/*
 * Serial channel with baud generator, error detection and request outputs, reached over APB.
 * Assumes pclk at 20 MHz, presetn asynchronous active low, and line pins resolved outside.
 */
// Register access over APB and the address map were chosen for this implementation.
// Functional notes
// RL1: 16-bit down-counting baud timer with reload, at half clock rate.
// RL2: Timer runs only while the channel is enabled.
// RL3: Baud reads give live count if enabled, else reload.
// RL4: Software writes reload only while disabled.
// RL5: Shift rate is clock / (2 * (reload + 1)).
// RL6: Slave software never programs reload zero.
// RL7: Receive and phase errors always; transmit and rate errors in slave only.
// RL8: Each error sets its flag; if enabled, also the shared error request.
// RL9: Error flags stay set until software clears them.
// RL10: Frame over unread buffer sets overrun flag, overwrites buffer.
// RL11: Data sampled per clock; change near latching edge sets phase error.
// RL12: Slave clock faster than double or slower than half sets rate error.
// RL13: Slave programs the master's rate for rate checks.
// RL14: Rate error with auto reset enabled reinitialises the channel.
// RL15: Slave frame without new transmit data sets stale flag, sends old.
// RL16: Unselected open-drain slaves send all ones.
// RL17: Slaves should load transmit data before each frame.
// RL18: Transmit, receive and error requests on separate outputs.
// RL19: Error request stays raised while an enabled flag is set.
// RL20: Error flags are held in the channel control register.
// RL21: Frame end loads receive buffer, raises receive request.
// RL22: Master sends first bit at next tick after load, if enabled.
// RL23: Timer reloads and ticks once per underflow.
`timescale 1ns/1ps
`include "ssbe_cfg.svh"

module ssbe_channel (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Shift clock pin
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe,
    // Master out line pin
    input wire logic master_out_line_i,
    output logic master_out_line_o,
    output logic master_out_line_oe,
    // Master in line pin
    input wire logic master_in_line_i,
    output logic master_in_line_o,
    output logic master_in_line_oe,
    // Requests
    output logic transmit_irq,
    output logic receive_irq,
    output logic error_irq_request
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Address match of one register word.
    function automatic logic ssbe_hit(input logic [11:0] addr, input logic [11:0] off);
        ssbe_hit = (addr == off);
    endfunction : ssbe_hit

    // Slave clock period bound: (reload + 1) shifted left.
    function automatic logic [18:0] ssbe_bound(input logic [15:0] rld, input int sh);
        logic [18:0] base;
        base = {3'h0, rld} + 19'h00001;
        ssbe_bound = base << sh;
    endfunction : ssbe_bound

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    logic [2:0] sy1_q, sy2_q, sy3_q;

    // Pins pass two flops; the third stage only serves edge detection.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sy1_q <= 3'h0;
            sy2_q <= 3'h0;
            sy3_q <= 3'h0;
        end
        else
        begin
            sy1_q <= {sclk_i, master_out_line_i, master_in_line_i};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
        end
    end

    // ------------------------------------------------------------------------
    // Baud timer
    // ------------------------------------------------------------------------
    ssbe_pkg::ssbe_ctrl_s ctrl_q, ctrl_d;
    logic [15:0] reload_q, reload_d;
    logic [15:0] cnt_q, cnt_d;
    logic pre_q, pre_d;
    logic tick, half;

    // Prescaler halves the clock for the counter.
    always_comb
    begin
        pre_d = pre_q;
        cnt_d = cnt_q;
        tick = 1'b0;
        half = 1'b0;
        if (!ctrl_q.channel_enable_bit)
        begin
            pre_d = 1'b0; // RL2
            cnt_d = reload_q; // RL2
        end
        else
        begin
            pre_d = ~pre_q; // RL1
            if (pre_q)
            begin
                if (cnt_q == 16'h0000)
                begin
                    cnt_d = reload_q; // RL23
                    tick = 1'b1; // RL23 RL5
                end
                else
                begin
                    cnt_d = cnt_q - 16'h0001; // RL1
                end
            end
            else if (cnt_q == (reload_q >> 1))
            begin
                half = 1'b1; // RL5
            end
        end
    end

    // Timer registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_q <= 1'b0;
            cnt_q <= `SSBE_RST_BAUD;
        end
        else
        begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------------------
    // Channel, registers and bus
    // ------------------------------------------------------------------------
    ssbe_pkg::ssbe_chan_e st_q, st_d;
    ssbe_pkg::ssbe_err_s flags_q, flags_d;
    logic [15:0] shreg_q, shreg_d, txbuf_q, txbuf_d, rxbuf_q, rxbuf_d;
    logic [4:0] bits_q, bits_d;
    logic [18:0] per_q, per_d;
    logic sclk_q, sclk_d, dout_q, dout_d;
    logic rxfull_q, rxfull_d, txpend_q, txpend_d, txnew_q, txnew_d;
    logic tirq_q, tirq_d, rirq_q, rirq_d, eirq_q, eirq_d;
    logic lat1_q, lat1_d, lat2_q, lat2_d, chgp_q, chgp_d;
    logic [31:0] prdata_q, prdata_d;
    logic slverr_q, slverr_d;
    logic din, chg, srise, latch, rxload, raterr, setup, access, mapped;
    logic [15:0] rxval;

    // Next channel state; bus clears come before hardware sets.
    always_comb
    begin
        st_d = st_q;
        flags_d = flags_q;
        shreg_d = shreg_q;
        txbuf_d = txbuf_q;
        rxbuf_d = rxbuf_q;
        bits_d = bits_q;
        per_d = per_q;
        sclk_d = sclk_q;
        dout_d = dout_q;
        rxfull_d = rxfull_q;
        txpend_d = txpend_q;
        txnew_d = txnew_q;
        ctrl_d = ctrl_q;
        reload_d = reload_q;
        lat1_d = 1'b0;
        lat2_d = lat1_q;
        tirq_d = 1'b0;
        rirq_d = 1'b0;
        rxload = 1'b0;
        rxval = shreg_q;
        raterr = 1'b0;
        latch = 1'b0;
        din = ctrl_q.master ? sy2_q[0] : sy2_q[1];
        chg = din ^ (ctrl_q.master ? sy3_q[0] : sy3_q[1]);
        chgp_d = chg;
        srise = sy2_q[2] & ~sy3_q[2];
        setup = psel & ~penable;
        access = psel & penable;
        mapped = ssbe_hit(paddr, `SSBE_OFF_CTRL) | ssbe_hit(paddr, `SSBE_OFF_BAUD) |
                 ssbe_hit(paddr, `SSBE_OFF_TXB) | ssbe_hit(paddr, `SSBE_OFF_RXB);
        prdata_d = prdata_q;
        slverr_d = slverr_q;
        // Read data and error are captured in the setup phase.
        if (setup)
        begin
            slverr_d = ~mapped;
            prdata_d = 32'h00000000;
            if (ssbe_hit(paddr, `SSBE_OFF_CTRL))
                prdata_d = {20'h00000, flags_q, 1'b0, ctrl_q}; // RL20
            else if (ssbe_hit(paddr, `SSBE_OFF_BAUD))
                prdata_d = {16'h0000, ctrl_q.channel_enable_bit ? cnt_q : reload_q}; // RL3
            else if (ssbe_hit(paddr, `SSBE_OFF_TXB))
                prdata_d = {16'h0000, txbuf_q};
            else if (ssbe_hit(paddr, `SSBE_OFF_RXB))
                prdata_d = {16'h0000, rxbuf_q};
        end
        // Bus effects in the access phase.
        if (access && pwrite)
        begin
            if (ssbe_hit(paddr, `SSBE_OFF_CTRL))
            begin
                ctrl_d = pwdata[`SSBE_CTRL_LSB +: 7];
                flags_d = flags_q & ~pwdata[`SSBE_FLAG_LSB +: 4]; // RL9
            end
            if (ssbe_hit(paddr, `SSBE_OFF_BAUD) && !ctrl_q.channel_enable_bit)
                reload_d = pwdata[15:0]; // RL4
            if (ssbe_hit(paddr, `SSBE_OFF_TXB))
            begin
                txbuf_d = pwdata[15:0];
                txpend_d = 1'b1;
                txnew_d = 1'b1;
            end
        end
        if (access && !pwrite && ssbe_hit(paddr, `SSBE_OFF_RXB))
            rxfull_d = 1'b0;
        // Transfer engine.
        if (!ctrl_q.channel_enable_bit)
        begin
            st_d = ssbe_pkg::SSBE_CH_IDLE;
            sclk_d = 1'b0;
            dout_d = `SSBE_LINE_IDLE;
            bits_d = 5'h00;
        end
        else if (ctrl_q.master)
        begin
            unique case (st_q)
                ssbe_pkg::SSBE_CH_IDLE:
                begin
                    if (tick && txpend_q)
                    begin
                        shreg_d = txbuf_q;
                        dout_d = txbuf_q[15]; // RL22
                        txpend_d = 1'b0;
                        txnew_d = 1'b0;
                        tirq_d = 1'b1;
                        bits_d = 5'h00;
                        st_d = ssbe_pkg::SSBE_CH_BUSY;
                    end
                end
                ssbe_pkg::SSBE_CH_BUSY:
                begin
                    if (half && !sclk_q)
                    begin
                        sclk_d = 1'b1;
                        latch = 1'b1;
                        shreg_d = {shreg_q[14:0], din};
                        bits_d = bits_q + 5'h01;
                    end
                    else if (tick && sclk_q)
                    begin
                        sclk_d = 1'b0;
                        dout_d = shreg_q[15];
                        if (bits_q == `SSBE_FRAME_BITS)
                        begin
                            rxload = 1'b1; // RL21
                            bits_d = 5'h00;
                            if (txpend_q)
                            begin
                                shreg_d = txbuf_q;
                                dout_d = txbuf_q[15];
                                txpend_d = 1'b0;
                                txnew_d = 1'b0;
                                tirq_d = 1'b1;
                            end
                            else
                            begin
                                st_d = ssbe_pkg::SSBE_CH_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
        else
        begin
            // Slave preloads the buffer and drives its first bit at once.
            if (st_q == ssbe_pkg::SSBE_CH_IDLE && txpend_q)
            begin
                shreg_d = txbuf_q;
                dout_d = txbuf_q[15];
                txpend_d = 1'b0;
                tirq_d = 1'b1;
            end
            sclk_d = sy2_q[2];
            per_d = per_q + 19'h00001;
            if (srise)
            begin
                latch = 1'b1;
                per_d = 19'h00000;
                shreg_d = {shreg_q[14:0], din};
                bits_d = bits_q + 5'h01;
                if (st_q == ssbe_pkg::SSBE_CH_IDLE)
                begin
                    st_d = ssbe_pkg::SSBE_CH_BUSY;
                    bits_d = 5'h01;
                    txnew_d = 1'b0;
                    if (!txnew_q)
                        flags_d.transmit_stale_flag = 1'b1; // RL15 RL7
                end
                else if (per_q < ssbe_bound(reload_q, `SSBE_RATE_LO_SH))
                begin
                    raterr = 1'b1; // RL12
                end
                if (bits_d == `SSBE_FRAME_BITS)
                begin
                    rxload = 1'b1; // RL21
                    rxval = {shreg_q[14:0], din};
                    dout_d = rxval[15]; // RL15
                    st_d = ssbe_pkg::SSBE_CH_IDLE;
                    bits_d = 5'h00;
                end
            end
            else if (sclk_q && !sy2_q[2] && st_q == ssbe_pkg::SSBE_CH_BUSY)
            begin
                dout_d = shreg_q[15];
            end
            if (st_q == ssbe_pkg::SSBE_CH_BUSY && per_q > ssbe_bound(reload_q, `SSBE_RATE_HI_SH))
                raterr = 1'b1; // RL12
            if (raterr)
            begin
                flags_d.rate_error_flag = 1'b1; // RL7 RL12
                if (ctrl_q.auto_reset_enable)
                begin
                    st_d = ssbe_pkg::SSBE_CH_IDLE; // RL14
                    bits_d = 5'h00; // RL14
                    per_d = 19'h00000; // RL14
                end
            end
        end
        if (st_q == ssbe_pkg::SSBE_CH_IDLE && ctrl_q.master)
            per_d = 19'h00000;
        // Receive buffer load with overrun check.
        if (rxload)
        begin
            rxbuf_d = rxval; // RL10
            rxfull_d = 1'b1;
            rirq_d = 1'b1; // RL21
            if (rxfull_q && !(access && !pwrite && ssbe_hit(paddr, `SSBE_OFF_RXB)))
                flags_d.receive_overrun_flag = 1'b1; // RL10
        end
        // Data change from one sample before to two after latching.
        lat1_d = latch & ctrl_q.channel_enable_bit;
        if (ctrl_q.channel_enable_bit && ((lat1_d && (chg || chgp_q)) || ((lat1_q || lat2_q) && chg)))
            flags_d.phase_error_flag = 1'b1; // RL11 RL7
        // Shared error request stays high while any enabled flag is set.
        eirq_d = (flags_d.receive_overrun_flag & ctrl_d.receive_overrun_enable) |
                 (flags_d.phase_error_flag & ctrl_d.phase_error_enable) |
                 (flags_d.rate_error_flag & ctrl_d.rate_error_enable) |
                 (flags_d.transmit_stale_flag & ctrl_d.transmit_stale_enable); // RL8 RL19
    end

    // Channel and register file registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= ssbe_pkg::SSBE_CH_IDLE;
            ctrl_q <= `SSBE_RST_CTRL;
            reload_q <= `SSBE_RST_BAUD;
            flags_q <= 4'h0;
            shreg_q <= `SSBE_RST_DATA;
            txbuf_q <= `SSBE_RST_DATA;
            rxbuf_q <= `SSBE_RST_DATA;
            bits_q <= 5'h00;
            per_q <= 19'h00000;
            sclk_q <= 1'b0;
            dout_q <= `SSBE_LINE_IDLE;
            rxfull_q <= 1'b0;
            txpend_q <= 1'b0;
            txnew_q <= 1'b0;
            tirq_q <= 1'b0;
            rirq_q <= 1'b0;
            eirq_q <= 1'b0;
            lat1_q <= 1'b0;
            lat2_q <= 1'b0;
            chgp_q <= 1'b0;
            prdata_q <= 32'h00000000;
            slverr_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            ctrl_q <= ctrl_d;
            reload_q <= reload_d;
            flags_q <= flags_d;
            shreg_q <= shreg_d;
            txbuf_q <= txbuf_d;
            rxbuf_q <= rxbuf_d;
            bits_q <= bits_d;
            per_q <= per_d;
            sclk_q <= sclk_d;
            dout_q <= dout_d;
            rxfull_q <= rxfull_d;
            txpend_q <= txpend_d;
            txnew_q <= txnew_d;
            tirq_q <= tirq_d;
            rirq_q <= rirq_d;
            eirq_q <= eirq_d;
            lat1_q <= lat1_d;
            lat2_q <= lat2_d;
            chgp_q <= chgp_d;
            prdata_q <= prdata_d;
            slverr_q <= slverr_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Master drives clock and out line; slave drives the in line.
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = slverr_q & psel & penable;
    assign sclk_o = sclk_q;
    assign sclk_oe = ctrl_q.channel_enable_bit & ctrl_q.master;
    assign master_out_line_o = dout_q;
    assign master_out_line_oe = ctrl_q.channel_enable_bit & ctrl_q.master;
    assign master_in_line_o = dout_q;
    assign master_in_line_oe = ctrl_q.channel_enable_bit & ~ctrl_q.master;
    assign transmit_irq = tirq_q; // RL18
    assign receive_irq = rirq_q; // RL18
    assign error_irq_request = eirq_q; // RL18

endmodule : ssbe_channel

// ===== ssbe_channel_monitor.sv
/* Port checker bound to every ssbe_channel.
   Assumes one pclk domain and the register map of the block. */
`timescale 1ns/1ps
`include "ssbe_cfg.svh"
module ssbe_channel_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Shift clock and requests
    input wire logic sclk_o,
    input wire logic transmit_irq,
    input wire logic receive_irq,
    input wire logic error_irq_request
);
    // ---------------------------------------------------------
    // Shadow state
    // ---------------------------------------------------------
    logic en_q;
    logic ms_q;
    logic [15:0] bd_q;
    logic [16:0] hi_q;
    wire ctl_w = psel && penable && pwrite && paddr == `SSBE_OFF_CTRL;
    // Mirrors enable, mode and reload, and counts clock high cycles.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_q <= 1'b0;
            ms_q <= 1'b0;
            bd_q <= 16'h0000;
            hi_q <= 17'h00000;
        end
        else
        begin
            if (ctl_w)
                {ms_q, en_q} <= pwdata[1:0];
            if (psel && penable && pwrite && paddr == `SSBE_OFF_BAUD && !en_q)
                bd_q <= pwdata[15:0];
            hi_q <= sclk_o ? hi_q + 17'h00001 : 17'h00000;
        end
    end
    // ---------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ready_high_a: assert property (pready) else $error("pready low");
    unmapped_err_a: assert property (psel && penable && paddr > `SSBE_OFF_RXB |-> pslverr)
        else $error("no error on unmapped address");
    upper_zero_a: assert property (psel && penable |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    tx_pulse_a: assert property (transmit_irq |=> !transmit_irq)
        else $error("transmit request too long");
    rx_pulse_a: assert property (receive_irq |=> !receive_irq)
        else $error("receive request too long");
    bit_time_a: assert property (en_q && ms_q && $fell(sclk_o) |-> hi_q == bd_q + 17'h00001)
        else $error("shift clock half period wrong");
    clock_still_a: assert property (!en_q && !$past(en_q) |-> $stable(sclk_o))
        else $error("shift clock moves while disabled");
    err_drop_a: assert property ($fell(error_irq_request) |-> $past(ctl_w) || $past(ctl_w, 2))
        else $error("error request dropped by itself");
endmodule : ssbe_channel_monitor

bind ssbe_channel ssbe_channel_monitor mon (.*);

// ===== ssbe_peer.sv
/* Far-side serial device: follows the channel as slave, or leads it as master.
   Assumes resolved line levels at its inputs and pclk for pacing. */
`timescale 1ns/1ps
module ssbe_peer (
    // Clock and resolved lines
    input wire logic pclk,
    input wire logic sck,
    input wire logic mo,
    input wire logic mi,
    // Levels driven by the peer
    output logic sclk = 1'b0,
    output logic mosi = 1'b1,
    output logic miso = 1'b1
);
    logic [15:0] sh = 16'hFFFF;
    logic [15:0] got_m = 16'h0000;
    logic [15:0] got_s = 16'h0000;
    logic sck_q = 1'b0;
    // As slave: latch on the rising clock, present the next bit after the fall.
    always @(posedge pclk)
    begin
        sck_q <= sck;
        if (sck && !sck_q)
            got_m <= {got_m[14:0], mo};
        if (!sck && sck_q)
            sh <= {sh[14:0], ~sh[15]};
        miso <= sh[15];
    end
    // Loads the word that the slave side shifts out next.
    task load(input logic [15:0] w);
        sh <= w;
    endtask : load
    // As master: one frame, MSB first; ph moves data onto the latching edge.
    task xfer(input logic [15:0] w, input int h, input logic ph);
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge pclk);
            mosi <= w[i];
            repeat (h) @(posedge pclk);
            sclk <= 1'b1;
            got_s <= {got_s[14:0], mi};
            if (ph)
                mosi <= ~w[i];
            repeat (h) @(posedge pclk);
            sclk <= 1'b0;
        end
        // Released data line shows the inverse level.
        @(posedge pclk);
        mosi <= ~mosi;
    endtask : xfer
endmodule : ssbe_peer

// ===== tb.sv
/* Self-checking bench for the serial channel: APB tasks, peer and checks.
   Assumes the design, peer and checker are compiled with it. */
`timescale 1ns/1ps
`include "ssbe_cfg.svh"
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, r, r1;
    logic pready, pslverr, sclk_o, sclk_oe, master_out_line_o, master_out_line_oe;
    logic master_in_line_o, master_in_line_oe, transmit_irq, receive_irq, error_irq_request;
    logic p_sclk, p_mosi, p_miso, err_q;
    wire sclk_i = sclk_oe ? sclk_o : p_sclk;
    wire master_out_line_i = master_out_line_oe ? master_out_line_o : p_mosi;
    wire master_in_line_i = master_in_line_oe ? master_in_line_o : p_miso;
    int fails = 0, samples_checked = 0, nrx = 0, ntx = 0;
    int hs[3] = '{4, 1, 10};
    logic ps[3] = '{1'b1, 1'b0, 1'b0};
    logic [31:0] ms[3] = '{32'h00000200, 32'h00000400, 32'h00000400};
    ssbe_channel dut (.*);
    ssbe_peer peer (.pclk(pclk), .sck(sclk_i), .mo(master_out_line_i), .mi(master_in_line_i),
        .sclk(p_sclk), .mosi(p_mosi), .miso(p_miso));
    // Clock at 20 MHz.
    always #25 pclk = ~pclk;
    // Counts request pulses.
    always @(posedge pclk)
    begin
        if (receive_irq === 1'b1)
            nrx++;
        if (transmit_irq === 1'b1)
            ntx++;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // One APB transfer; read data and error are taken at the ready edge.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(r & m, e);
    endtask : rd
    // One frame led by the channel (m) or the peer, then a bounded wait.
    task run(input logic m, input logic [15:0] w, input logic [15:0] t, input int h, input logic ph);
        int n0;
        n0 = nrx;
        if (m)
        begin
            peer.load(w);
            wr(`SSBE_OFF_TXB, {16'h0000, t});
        end
        else
            peer.xfer(w, h, ph);
        repeat (300) if (nrx == n0) @(posedge pclk);
        chk(nrx != n0, 32'h00000001);
    endtask : run
    task give_verdict;
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    // Cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        give_verdict();
    end
    // Main sequence.
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`SSBE_OFF_CTRL, 32'hFFFFFFFF, 32'h00000000);
        rd(`SSBE_OFF_BAUD, 32'hFFFFFFFF, 32'h00000000);
        rd(12'h010, 32'hFFFFFFFF, 32'h00000000);
        chk(err_q, 32'h00000001);
        wr(`SSBE_OFF_BAUD, 32'h00000005);
        rd(`SSBE_OFF_BAUD, 32'hFFFFFFFF, 32'h00000005);
        wr(`SSBE_OFF_CTRL, 32'h00000001);
        apb(1'b0, `SSBE_OFF_BAUD, 32'h00000000);
        r1 = r;
        apb(1'b0, `SSBE_OFF_BAUD, 32'h00000000);
        chk(r != r1, 32'h00000001);
        chk(r <= 32'h00000005, 32'h00000001);
        wr(`SSBE_OFF_BAUD, 32'h00000009);
        wr(`SSBE_OFF_CTRL, 32'h00000000);
        rd(`SSBE_OFF_BAUD, 32'hFFFFFFFF, 32'h00000005);
        wr(`SSBE_OFF_BAUD, 32'h00000006);
        wr(`SSBE_OFF_CTRL, 32'h00000007);
        run(1'b1, 16'hA55A, 16'h3C96, 0, 1'b0);
        chk(peer.got_m, 32'h00003C96);
        chk(ntx, 32'h00000001);
        chk(nrx, 32'h00000001);
        run(1'b1, 16'h0F0F, 16'hC3A5, 0, 1'b0);
        rd(`SSBE_OFF_RXB, 32'hFFFFFFFF, 32'h00000F0F);
        rd(`SSBE_OFF_CTRL, 32'hFFFFFFFF, 32'h00000107);
        chk(error_irq_request, 32'h00000001);
        wr(`SSBE_OFF_CTRL, 32'h00000107);
        rd(`SSBE_OFF_CTRL, 32'hFFFFFFFF, 32'h00000007);
        chk(error_irq_request, 32'h00000000);
        wr(`SSBE_OFF_CTRL, 32'h00000000);
        wr(`SSBE_OFF_BAUD, 32'h00000003);
        wr(`SSBE_OFF_CTRL, 32'h00000039);
        wr(`SSBE_OFF_TXB, 32'h00001234);
        run(1'b0, 16'hBEEF, 16'h0000, 4, 1'b0);
        rd(`SSBE_OFF_RXB, 32'hFFFFFFFF, 32'h0000BEEF);
        chk(peer.got_s, 32'h00001234);
        rd(`SSBE_OFF_CTRL, 32'h0000FF00, 32'h00000000);
        run(1'b0, 16'h5AA5, 16'h0000, 4, 1'b0);
        chk(peer.got_s, 32'h0000BEEF);
        rd(`SSBE_OFF_CTRL, 32'h00000800, 32'h00000800);
        chk(error_irq_request, 32'h00000001);
        wr(`SSBE_OFF_CTRL, 32'h00000F39);
        for (int i = 0; i < 3; i++)
        begin
            wr(`SSBE_OFF_TXB, 32'h0000FFFF);
            run(1'b0, 16'h6699, 16'h0000, hs[i], ps[i]);
            rd(`SSBE_OFF_CTRL, ms[i], ms[i]);
            wr(`SSBE_OFF_CTRL, 32'h00000F39);
        end
        give_verdict();
    end
endmodule : tb
